// ### design/lcr_field_decode.sv
// Registered decode of the lead-off and channel one fields
`timescale 1ns/1ps
module lcr_field_decode
  import lcr_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  lcr_cfg_if.dec    cfg
);

  function automatic logic [7:0] thr_pos(input logic [2:0] code);
    logic [7:0] v;
    v = 8'd190;
    unique case (code)
      3'h0: v = 8'd190;
      3'h1: v = 8'd185;
      3'h2: v = 8'd180;
      3'h3: v = 8'd175;
      3'h4: v = 8'd170;
      3'h5: v = 8'd160;
      3'h6: v = 8'd150;
      3'h7: v = 8'd140;
    endcase
    return v;
  endfunction

  wire logic [2:0] thr_code  = cfg.lead_off_control[LCR_THR_MSB:LCR_THR_LSB];
  wire logic [1:0] cur_code  = cfg.lead_off_control[LCR_CUR_MSB:LCR_CUR_LSB];
  wire logic [2:0] gain_code =
    cfg.channel_one_settings[LCR_GAIN_MSB:LCR_GAIN_LSB];
  wire logic [3:0] mux_code  =
    cfg.channel_one_settings[LCR_MUX_MSB:LCR_MUX_LSB];
  wire logic       pd        = cfg.channel_one_settings[LCR_PD_BIT];

  wire logic [7:0] pos_next = thr_pos(thr_code);
  wire logic [7:0] neg_next = 8'd200 - pos_next;
  wire logic [14:0] cur_next = (cur_code == 2'h0) ? 15'd6 :
                               (cur_code == 2'h1) ? 15'd22 :
                               (cur_code == 2'h2) ? 15'd6000 : 15'd22000;
  wire logic [3:0] gain_next = (gain_code == 3'h0) ? 4'd6 :
                               (gain_code == 3'h5) ? 4'd8 :
                               (gain_code == 3'h6) ? 4'd12 :
                               (gain_code == LCR_GAIN_UNDEF) ? 4'd0 :
                               {1'b0, gain_code};
  // input select, reserved codes select nothing
  wire logic       mux_bad   = mux_code > LCR_MUX_LAST;
  wire logic [9:0] mux_next  = mux_bad ? 10'h000 :
                               10'((11'h001 << mux_code));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg.thr_pos_half_pct <= 8'd190;
      cfg.thr_neg_half_pct <= 8'd10;
      cfg.excite_na        <= 15'd6;
      cfg.ch_one_gain      <= 4'd6;
      cfg.input_onehot     <= 10'h001;
      cfg.gain_undefined   <= 1'b0;
      cfg.input_undefined  <= 1'b0;
      cfg.pd_not_shorted   <= 1'b0;
      cfg.supply_not_unity <= 1'b0;
    end else begin
      cfg.thr_pos_half_pct <= pos_next;
      cfg.thr_neg_half_pct <= neg_next;
      cfg.excite_na        <= cur_next;
      cfg.ch_one_gain      <= gain_next;
      cfg.input_onehot     <= mux_next;
      cfg.gain_undefined   <= gain_code == LCR_GAIN_UNDEF;
      cfg.input_undefined  <= mux_bad;
      cfg.pd_not_shorted   <= pd && (mux_code != LCR_MUX_SHORTED);
      cfg.supply_not_unity <= (mux_code == LCR_MUX_SUPPLY) &&
                              (gain_code != LCR_GAIN_UNITY);
    end
  end

endmodule

// ### design/lcr_regs.sv
// APB register bank for lead-off control and channel one settings
//
// What this block does
// - Channel one settings sit at index 04h
// - Lead-off control sits at index 03h
// - Threshold code sets both comparator sides
// - Current code picks 6nA to 22uA
// - Low bit picks dc or quarter-rate ac
// - Channel one power-down bit, zero runs
// - Gain code maps to 6,1,2,3,4,8,12
// - Input select code 0-9 picks one input path
`timescale 1ns/1ps
module lcr_regs
  import lcr_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              data_rate_tick,
  output logic [2:0]             comparator_threshold_code,
  output logic [7:0]             thr_pos_half_pct,
  output logic [7:0]             thr_neg_half_pct,
  output logic [1:0]             excitation_current_code,
  output logic [14:0]            excitation_current_na,
  output logic                   detect_style_select,
  output logic                   excite_phase,
  output logic                   ch_one_power_down,
  output logic [2:0]             ch_one_amp_code,
  output logic [3:0]             ch_one_gain,
  output logic [3:0]             ch_one_input_select,
  output logic [9:0]             ch_one_input_onehot
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  lead_off_reg;
  logic [7:0]  lead_off_next;
  logic [7:0]  ch_one_reg;
  logic [7:0]  ch_one_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [1:0]  tick_cnt_reg;
  logic [1:0]  tick_cnt_next;
  logic        phase_reg;
  logic        phase_next;

  lcr_cfg_if cfg ();

  lcr_field_decode u_decode (
    .clk    (clk),
    .resetn (resetn),
    .cfg    (cfg)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [9:0]        idx);
    return (a[1:0] == 2'b00) &&
           (a[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  wire logic hit_lead  = hit(paddr, LCR_IDX_LEAD_OFF);
  // channel one settings at its index
  wire logic hit_ch    = hit(paddr, LCR_IDX_CH_ONE);
  wire logic hit_stat  = hit(paddr, LCR_IDX_STATUS);
  wire logic mapped    = hit_lead || hit_ch || hit_stat;

  wire logic setup     = psel && !penable;
  wire logic access    = psel && penable;
  // Status is read-only, so a write to it is refused like a miss
  wire logic bad_xfer  = !mapped || (hit_stat && pwrite);
  wire logic wr_ok     = access && pwrite && !bad_xfer && pstrb[0];
  wire logic wr_lead   = wr_ok && hit_lead;
  wire logic wr_ch     = wr_ok && hit_ch;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  // Bit 4 always reads one and bit 1 zero, whatever is written
  function automatic logic [7:0] lead_fix(input logic [7:0] v);
    logic [7:0] f;
    f = v;
    f[LCR_ONE_BIT]  = 1'b1;
    f[LCR_ZERO_BIT] = 1'b0;
    return f;
  endfunction

  assign lead_off_next = wr_lead ? lead_fix(pwdata[7:0]) : lead_off_reg;
  assign ch_one_next   = wr_ch ? pwdata[7:0] : ch_one_reg;

  // Flags only report; host-side rules are left to the host
  wire logic [7:0] status_byte = {
    3'b000,
    phase_reg,
    cfg.input_undefined,
    cfg.gain_undefined,
    cfg.supply_not_unity,
    cfg.pd_not_shorted
  };

  wire logic [7:0] rd_byte = hit_lead ? lead_off_reg :
                             hit_ch   ? ch_one_reg   :
                             hit_stat ? status_byte  : 8'h00;

  // Read data is captured in setup so the access phase needs no wait
  assign prdata_next = (setup && !pwrite) ? {24'h000000, rd_byte} :
                                            prdata_reg;

  // ----------------------------------------------------------------
  // Ac excitation at a quarter of the output data rate
  // ----------------------------------------------------------------
  // divide the data-rate tick by four
  wire logic ac_on = lead_off_reg[LCR_STYLE_BIT];
  wire logic half  = tick_cnt_reg == 2'((LCR_AC_DIV / 2) - 1);
  // Held at zero in dc mode so ac always starts on a fresh phase
  assign tick_cnt_next = !ac_on ? 2'b00 :
                         !data_rate_tick ? tick_cnt_reg :
                         half ? 2'b00 : tick_cnt_reg + 2'b01;
  assign phase_next    = !ac_on ? 1'b0 :
                         (data_rate_tick && half) ? !phase_reg : phase_reg;

  // ----------------------------------------------------------------
  // Register updates
  // ----------------------------------------------------------------
  // lead-off control holds written fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lead_off_reg <= LCR_LEAD_OFF_RST;
    end else begin
      lead_off_reg <= lead_off_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ch_one_reg <= LCR_CH_ONE_RST;
    end else begin
      ch_one_reg <= ch_one_next;
    end
  end

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  // Holds until the next read setup, so a slow host still sees it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Excitation divider state
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= 2'b00;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfg.lead_off_control     = lead_off_reg;
  assign cfg.channel_one_settings = ch_one_reg;

  assign prdata  = prdata_reg;
  // No wait states: read data already sits in flip-flops
  assign pready  = 1'b1;
  // A refused write changes nothing and a refused read captures zero read data; this flag answers both
  assign pslverr = access && bad_xfer;

  assign comparator_threshold_code =
    lead_off_reg[LCR_THR_MSB:LCR_THR_LSB];
  assign thr_pos_half_pct = cfg.thr_pos_half_pct;
  assign thr_neg_half_pct = cfg.thr_neg_half_pct;
  assign excitation_current_code =
    lead_off_reg[LCR_CUR_MSB:LCR_CUR_LSB];
  assign excitation_current_na = cfg.excite_na;
  assign detect_style_select = ac_on;
  assign excite_phase        = phase_reg;
  assign ch_one_power_down   = ch_one_reg[LCR_PD_BIT];
  assign ch_one_amp_code     = ch_one_reg[LCR_GAIN_MSB:LCR_GAIN_LSB];
  assign ch_one_gain         = cfg.ch_one_gain;
  assign ch_one_input_select = ch_one_reg[LCR_MUX_MSB:LCR_MUX_LSB];
  assign ch_one_input_onehot = cfg.input_onehot;

endmodule

// ### inc/lcr_cfg_if.sv
// Carrier between the register bank and its field decoder
`timescale 1ns/1ps
interface lcr_cfg_if;
  logic [7:0]  lead_off_control;
  logic [7:0]  channel_one_settings;
  logic [7:0]  thr_pos_half_pct;
  logic [7:0]  thr_neg_half_pct;
  logic [14:0] excite_na;
  logic [3:0]  ch_one_gain;
  logic [9:0]  input_onehot;
  logic        gain_undefined;
  logic        input_undefined;
  logic        pd_not_shorted;
  logic        supply_not_unity;

  modport bank (
    output lead_off_control, channel_one_settings,
    input  thr_pos_half_pct, thr_neg_half_pct, excite_na, ch_one_gain,
    input  input_onehot, gain_undefined, input_undefined,
    input  pd_not_shorted, supply_not_unity
  );
  modport dec (
    input  lead_off_control, channel_one_settings,
    output thr_pos_half_pct, thr_neg_half_pct, excite_na, ch_one_gain,
    output input_onehot, gain_undefined, input_undefined,
    output pd_not_shorted, supply_not_unity
  );
endinterface

// ### inc/lcr_pkg.sv
// Constants shared by the lead-off and channel one configuration bank
package lcr_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] LCR_IDX_LEAD_OFF = 10'h003;
  localparam logic [9:0] LCR_IDX_CH_ONE   = 10'h004;
  localparam logic [9:0] LCR_IDX_STATUS   = 10'h008;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LCR_LEAD_OFF_RST = 8'h10;
  localparam logic [7:0] LCR_CH_ONE_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Lead-off field layout
  // ----------------------------------------------------------------
  localparam int LCR_THR_MSB   = 7;
  localparam int LCR_THR_LSB   = 5;
  localparam int LCR_ONE_BIT   = 4;
  localparam int LCR_CUR_MSB   = 3;
  localparam int LCR_CUR_LSB   = 2;
  localparam int LCR_ZERO_BIT  = 1;
  localparam int LCR_STYLE_BIT = 0;

  // ----------------------------------------------------------------
  // Channel one field layout
  // ----------------------------------------------------------------
  localparam int LCR_PD_BIT    = 7;
  localparam int LCR_GAIN_MSB  = 6;
  localparam int LCR_GAIN_LSB  = 4;
  localparam int LCR_MUX_MSB   = 3;
  localparam int LCR_MUX_LSB   = 0;

  // ----------------------------------------------------------------
  // Status register bits
  // ----------------------------------------------------------------
  localparam int LCR_ST_PD_OPEN   = 0;
  localparam int LCR_ST_SUP_GAIN  = 1;
  localparam int LCR_ST_BAD_GAIN  = 2;
  localparam int LCR_ST_BAD_INPUT = 3;
  localparam int LCR_ST_EXCITE    = 4;

  // ----------------------------------------------------------------
  // Codes and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] LCR_MUX_SHORTED  = 4'h1;
  localparam logic [3:0] LCR_MUX_SUPPLY   = 4'h3;
  localparam logic [3:0] LCR_MUX_LAST     = 4'h9;
  localparam logic [2:0] LCR_GAIN_UNITY   = 3'h1;
  localparam logic [2:0] LCR_GAIN_UNDEF   = 3'h7;
  localparam int         LCR_AC_DIV       = 4;
  localparam int         LCR_INPUTS       = 10;

endpackage

// ### verif/lcr_apb_host.sv
// APB host model that programs the bank from the software side
`timescale 1ns/1ps
module lcr_apb_host (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  function automatic logic [7:0] ch_fix(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (r[6:4] == 3'h7)
      r[6:4] = 3'h6;
    if (r[3:0] > 4'h9)
      r[3:0] = {1'b0, r[2:0]};
    if (r[7])
      r[3:0] = 4'h1;
    if (r[3:0] == 4'h3)
      r[6:4] = 3'h1;
    return r;
  endfunction

  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    // Reads carry no strobes
    pstrb <= w ? s : 4'h0;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle data never repeats the last value
    pwdata <= ~pwdata;
  endtask
endmodule

// ### verif/lcr_regs_asserts.sv
// Port checks for the lead-off and channel one register bank
`timescale 1ns/1ps
module lcr_regs_asserts
  import lcr_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pslverr,
  input wire logic              data_rate_tick,
  input wire logic [2:0]        comparator_threshold_code,
  input wire logic [7:0]        thr_pos_half_pct,
  input wire logic [7:0]        thr_neg_half_pct,
  input wire logic [1:0]        excitation_current_code,
  input wire logic [14:0]       excitation_current_na,
  input wire logic              detect_style_select,
  input wire logic              excite_phase,
  input wire logic              ch_one_power_down,
  input wire logic [2:0]        ch_one_amp_code,
  input wire logic [3:0]        ch_one_gain,
  input wire logic [3:0]        ch_one_input_select,
  input wire logic [9:0]        ch_one_input_onehot
);
  // ----------------------------------------------------------------
  // Expected decodes and write strobes
  // ----------------------------------------------------------------
  localparam logic [7:0]  THR [8] = '{8'hbe, 8'hb9, 8'hb4, 8'haf,
                                      8'haa, 8'ha0, 8'h96, 8'h8c};
  localparam logic [14:0] CUR [4] = '{15'h6, 15'h16, 15'h1770, 15'h55f0};
  localparam logic [3:0]  GT [8]  = '{4'h6, 4'h1, 4'h2, 4'h3,
                                      4'h4, 4'h8, 4'hc, 4'h0};
  wire wr_take = psel && penable && pwrite && pstrb[0];
  wire hit_lo  = paddr == {LCR_IDX_LEAD_OFF, 2'b00};
  wire hit_ch  = paddr == {LCR_IDX_CH_ONE, 2'b00};
  wire hit_st  = paddr == {LCR_IDX_STATUS, 2'b00};

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_LEAD_OFF_CONTROL_WRITE: assert property (wr_take && hit_lo |=>
    {comparator_threshold_code, excitation_current_code,
     detect_style_select} == {$past(pwdata[7:5]), $past(pwdata[3:2]),
     $past(pwdata[0])}) else $error("lead-off fields differ from write");
  AST_CH_WRITE: assert property (wr_take && hit_ch |=>
    {ch_one_power_down, ch_one_amp_code, ch_one_input_select}
    == $past(pwdata[7:0])) else $error("channel fields differ from write");
  AST_THR_POS: assert property (
    thr_pos_half_pct == THR[$past(comparator_threshold_code)])
    else $error("positive threshold wrong");
  AST_THR_SUM: assert property (
    thr_pos_half_pct + thr_neg_half_pct == 8'hc8)
    else $error("threshold sides do not add up");
  AST_CUR: assert property (
    excitation_current_na == CUR[$past(excitation_current_code)])
    else $error("excitation current wrong");
  AST_DC_PHASE: assert property (
    !detect_style_select [*2] |-> !excite_phase)
    else $error("phase moves in dc mode");
  AST_PHASE_HOLD: assert property (
    detect_style_select && !data_rate_tick ##1 detect_style_select
    |-> $stable(excite_phase)) else $error("phase moved without tick");
  AST_GAIN: assert property (
    ch_one_gain == GT[$past(ch_one_amp_code)]) else $error("gain wrong");
  AST_ONEHOT: assert property (
    ch_one_input_onehot == ($past(ch_one_input_select) <= 4'h9 ?
    10'h001 << $past(ch_one_input_select) : 10'h000))
    else $error("input one-hot wrong");
  AST_UNMAPPED: assert property (
    psel && penable && !(hit_lo || hit_ch || hit_st) |-> pslverr)
    else $error("unmapped access not refused");

  cover property (wr_take && hit_ch);
  cover property (wr_take && hit_lo);
  cover property (detect_style_select && data_rate_tick);
endmodule

bind lcr_regs lcr_regs_asserts #(.ADDR_W(ADDR_W)) u_lcr_chk (
  .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pslverr, .data_rate_tick, .comparator_threshold_code,
  .thr_pos_half_pct, .thr_neg_half_pct, .excitation_current_code,
  .excitation_current_na, .detect_style_select, .excite_phase,
  .ch_one_power_down, .ch_one_amp_code, .ch_one_gain,
  .ch_one_input_select, .ch_one_input_onehot);

// ### verif/lcr_regs_bench.sv
// Self-checking bench for the lead-off and channel one bank
`timescale 1ns/1ps
module lcr_regs_bench;
  logic clk, resetn, data_rate_tick, psel, penable, pwrite;
  logic pready, pslverr, detect_style_select, excite_phase;
  logic ch_one_power_down;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb, ch_one_gain, ch_one_input_select;
  logic [2:0]  comparator_threshold_code, ch_one_amp_code;
  logic [7:0]  thr_pos_half_pct, thr_neg_half_pct, d, lo_exp;
  logic [1:0]  excitation_current_code;
  logic [14:0] excitation_current_na;
  logic [9:0]  ch_one_input_onehot;
  logic        ph_q;
  int errors, cmp_count, cyc, tog;
  localparam logic [7:0]  THR [8] = '{8'hbe, 8'hb9, 8'hb4, 8'haf,
                                      8'haa, 8'ha0, 8'h96, 8'h8c};
  localparam logic [14:0] CUR [4] = '{15'h6, 15'h16, 15'h1770, 15'h55f0};
  localparam logic [3:0]  GT [8]  = '{4'h6, 4'h1, 4'h2, 4'h3,
                                      4'h4, 4'h8, 4'hc, 4'h0};

  lcr_regs uut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .data_rate_tick,
    .comparator_threshold_code, .thr_pos_half_pct, .thr_neg_half_pct,
    .excitation_current_code, .excitation_current_na,
    .detect_style_select, .excite_phase, .ch_one_power_down,
    .ch_one_amp_code, .ch_one_gain, .ch_one_input_select,
    .ch_one_input_onehot);
  lcr_apb_host uh (.clk, .prdata, .pready, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [31:0] exp_hot(input logic [3:0] m);
    return (m <= 4'h9) ? 32'h1 << m : 32'h0;
  endfunction

  task automatic acc(input int w, input logic [11:0] a,
                     input logic [7:0] v, input logic [3:0] s,
                     input int ee);
    logic e;
    uh.xfer(1'(w), a, v, s, r, e);
    chk("pslverr", 32'(ee), {31'h0, e});
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    ph_q <= excite_phase;
    if (resetn && ph_q !== excite_phase)
      tog <= tog + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    data_rate_tick = 1'b0;
    cyc = 0;
    tog = 0;
    void'($urandom(32'hf34e4318));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    acc(0, 12'h00c, 8'h0, 4'hf, 0);
    chk("lead_off", 32'h10, r);
    acc(0, 12'h010, 8'h0, 4'hf, 0);
    chk("ch_one", 32'h0, r);
    chk("gain", 32'h6, {28'h0, ch_one_gain});
    $display("test reset done");
    for (int t = 0; t < 8; t++) begin
      d = 8'($urandom);
      d[7:5] = t[2:0];
      d[3:2] = t[1:0];
      acc(1, 12'h00c, d, 4'h1, 0);
      acc(0, 12'h00c, 8'h0, 4'hf, 0);
      lo_exp = {d[7:5], 1'b1, d[3:2], 1'b0, d[0]};
      chk("lead_off", {24'h0, lo_exp}, r);
      chk("thr_pos", THR[t], thr_pos_half_pct);
      chk("thr_neg", 8'hc8 - THR[t], thr_neg_half_pct);
      chk("cur", CUR[t[1:0]], excitation_current_na);
    end
    $display("test lead-off done");
    for (int g = 0; g < 7; g++) begin
      for (int m = 0; m < 10; m++) begin
        d = uh.ch_fix({1'($urandom), g[2:0], m[3:0]});
        acc(1, 12'h010, d, 4'h1, 0);
        acc(0, 12'h010, 8'h0, 4'hf, 0);
        chk("ch_one", {24'h0, d}, r);
        chk("pd", d[7], ch_one_power_down);
        chk("gain", GT[d[6:4]], ch_one_gain);
        chk("onehot", exp_hot(d[3:0]), ch_one_input_onehot);
      end
    end
    $display("test channel done");
    acc(1, 12'h010, 8'h25, 4'h0, 0);
    acc(1, 12'h020, 8'hff, 4'h1, 1);
    acc(1, 12'h00d, 8'h00, 4'h1, 1);
    acc(0, 12'h014, 8'h0, 4'hf, 1);
    acc(0, 12'h010, 8'h0, 4'hf, 0);
    chk("ch_one", {24'h0, d}, r);
    acc(0, 12'h00c, 8'h0, 4'hf, 0);
    chk("lead_off", {24'h0, lo_exp}, r);
    $display("test refusal done");
    // Codes a careful host never writes, to see the status flags
    acc(1, 12'h010, 8'hf3, 4'h1, 0);
    acc(0, 12'h020, 8'h0, 4'hf, 0);
    chk("status", 32'h07, r);
    chk("gain", 32'h0, {28'h0, ch_one_gain});
    acc(1, 12'h010, 8'h0c, 4'h1, 0);
    acc(0, 12'h020, 8'h0, 4'hf, 0);
    chk("status", 32'h08, r);
    chk("onehot", 32'h0, {22'h0, ch_one_input_onehot});
    $display("test status done");
    acc(1, 12'h00c, 8'h01, 4'h1, 0);
    repeat (2) @(posedge clk);
    tog = 0;
    // Ten ticks at two per flip leave the phase high
    repeat (10) begin
      data_rate_tick <= 1'b1;
      @(posedge clk);
      data_rate_tick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    chk("phase toggles", 32'h5, 32'(tog));
    acc(1, 12'h00c, 8'h00, 4'h1, 0);
    repeat (3) @(posedge clk);
    chk("phase", 32'h0, {31'h0, excite_phase});
    $display("test excitation done");
    give_verdict();
  end
endmodule
